// ==== hdl/urx_receiver.sv ====
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`timescale 1ns/100ps
module urx_receiver
	import urx_pkg::*;
(
	input  wire logic        mclk_in,
	input  wire logic        rst_n_in,
	input  wire logic        rxd_in,
	input  wire logic        wb_cyc_in,
	input  wire logic        wb_stb_in,
	input  wire logic        wb_we_in,
	input  wire logic [7:0]  wb_adr_in,
	input  wire logic [3:0]  wb_sel_in,
	input  wire logic [31:0] wb_dat_in,
	output logic      [31:0] wb_dat_out,
	output logic             wb_ack_out,
	output logic             rx_irq_out,
	output logic             err_irq_out
);

	// ==========================================================================
	// Declarations.
	// ==========================================================================
	logic             rx_meta, rx_sync, tick;
	logic [15:0]      divisor;
	logic [15:0]      div_cnt;
	urx_state_t       state;
	logic [4:0]       phase;
	logic [3:0]       bit_idx;
	logic [2:0]       hist;
	logic             smp_a, smp_b, noise_pend, last_bit;
	logic [8:0]       shift_reg;
	logic             done, done_framing, done_noise;
	logic [8:0]       done_data;
	logic [7:0]       control_one, control_two, control_three;
	logic [8:0]       data_buffer;
	logic             receive_full_flag, quiet_flag, overrun_flag;
	logic             noise_flag, framing_fault_flag, parity_fault_flag;
	logic [7:0]       quiet_cnt;
	logic             quiet_armed, nine_bit, receiver_standby, wake_addr;
	logic [7:0]       quiet_target;
	logic             quiet_line, ones_many, ones_one, vote, disagree;
	logic             fall_edge, last_data_bit, bus_req, wr_en;
	logic             rd_data_buffer, wr_status;
	logic [31:0]      next_dat, status_word;
	logic             done_msb, parity_bad, accept, quiet_event;

	assign nine_bit         = control_one[URX_C1_NINE_BIT];
	assign wake_addr        = control_one[URX_C1_WAKE_ADDR];
	assign receiver_standby = control_two[URX_C2_STANDBY];

	// ==========================================================================
	// Input synchroniser and sample tick.
	// ==========================================================================
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rx_meta <= 1'b1;
			rx_sync <= 1'b1;
		end else begin
			rx_meta <= rxd_in;
			rx_sync <= rx_meta;
		end
	end

	// The divisor gives module clocks per sample tick; zero acts as one.
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			div_cnt <= 16'h0000;
		end else if (div_cnt == 16'h0000 || div_cnt >= divisor) begin
			div_cnt <= (divisor > 16'h0001) ? divisor - 16'h0001 : 16'h0000;
		end else begin
			div_cnt <= div_cnt - 16'h0001;
		end
	end

	assign tick = (div_cnt == 16'h0000);

	// ==========================================================================
	// Sample voting.
	// ==========================================================================
	assign ones_many = (smp_a & smp_b) | (smp_a & rx_sync) | (smp_b & rx_sync);
	assign ones_one  = (smp_a ^ smp_b ^ rx_sync) & ~(smp_a & smp_b & rx_sync);
	assign vote      = ones_many;
	assign disagree  = ~((smp_a == smp_b) && (smp_b == rx_sync));
	assign fall_edge = hist[0] & ~rx_sync & last_bit;
	assign last_data_bit = (bit_idx == (nine_bit ? 4'h8 : 4'h7));

	// ==========================================================================
	// Data recovery state machine; phase holds the sample number being taken.
	// ==========================================================================
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state        <= URX_HUNT;
			phase        <= 5'h01;
			bit_idx      <= 4'h0;
			hist         <= 3'b000;
			smp_a        <= 1'b0;
			smp_b        <= 1'b0;
			noise_pend   <= 1'b0;
			last_bit     <= 1'b0;
			shift_reg    <= 9'h000;
			done         <= 1'b0;
			done_framing <= 1'b0;
			done_noise   <= 1'b0;
			done_data    <= 9'h000;
		end else begin
			done <= 1'b0;
			if (tick) begin
				hist  <= {hist[1:0], rx_sync};
				phase <= (phase == URX_TICKS_PER_BIT) ? 5'h01 : phase + 5'h01;
				unique case (state)
					URX_HUNT: begin
						phase <= 5'h01;
						if (hist == 3'b111 && !rx_sync) begin
							state      <= URX_START;
							phase      <= 5'h02;
							noise_pend <= 1'b0;
						end
					end
					URX_START: begin
						if (phase == 5'h03 || phase == 5'h08) begin
							smp_a <= rx_sync;
						end
						if (phase == 5'h05 || phase == 5'h09) begin
							smp_b <= rx_sync;
						end
						if (phase == 5'h07) begin
							if (ones_many) begin
								state <= URX_HUNT;
								phase <= 5'h01;
							end else if (ones_one) begin
								noise_pend <= 1'b1;
							end
						end
						if (phase == 5'h0A && (smp_a | smp_b | rx_sync)) begin
							noise_pend <= 1'b1;
						end
						if (phase == URX_TICKS_PER_BIT) begin
							state    <= URX_DATA;
							bit_idx  <= 4'h0;
							last_bit <= 1'b0;
						end
					end
					URX_DATA: begin
						if (fall_edge && phase >= 5'h0B) begin
							phase   <= 5'h02;
							bit_idx <= bit_idx + 4'h1;
							if (last_data_bit) begin
								state <= URX_STOP;
							end
						end else if (fall_edge && phase >= 5'h02 && phase <= 5'h07) begin
							phase <= 5'h02;
						end else begin
							if (phase == 5'h08) begin
								smp_a <= rx_sync;
							end
							if (phase == 5'h09) begin
								smp_b <= rx_sync;
							end
							if (phase == 5'h0A) begin
								shift_reg <= {vote, shift_reg[8:1]};
								last_bit  <= vote;
								if (disagree) begin
									noise_pend <= 1'b1;
								end
							end
							if (phase == URX_TICKS_PER_BIT) begin
								bit_idx <= bit_idx + 4'h1;
								if (last_data_bit) begin
									state <= URX_STOP;
								end
							end
						end
					end
					URX_STOP: begin
						if (fall_edge && phase >= 5'h02 && phase <= 5'h07) begin
							phase <= 5'h02;
						end
						if (phase == 5'h08) begin
							smp_a <= rx_sync;
						end
						if (phase == 5'h09) begin
							smp_b <= rx_sync;
						end
						if (phase == 5'h0A) begin
							state        <= URX_HUNT;
							phase        <= 5'h01;
							done         <= 1'b1;
							done_framing <= ~vote;
							done_noise   <= noise_pend | disagree;
							done_data    <= nine_bit ? shift_reg : {1'b0, shift_reg[8:1]};
						end
					end
				endcase
			end
		end
	end

	// ==========================================================================
	// Idle line detection.
	// ==========================================================================
	assign quiet_target = nine_bit ? URX_QUIET_TICKS_9 : URX_QUIET_TICKS_8;
	assign quiet_line   = (quiet_cnt >= quiet_target);
	assign quiet_event  = quiet_armed & quiet_line;

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			quiet_cnt   <= 8'h00;
			quiet_armed <= 1'b0;
		end else begin
			if (tick) begin
				if (!rx_sync || state == URX_START) begin
					quiet_cnt <= 8'h00;
				end else if (control_one[URX_C1_QUIET_START] && state != URX_HUNT) begin
					quiet_cnt <= 8'h00;
				end else if (!quiet_line) begin
					quiet_cnt <= quiet_cnt + 8'h01;
				end
			end
			if (state == URX_START) begin
				quiet_armed <= 1'b1;
			end else if (quiet_event) begin
				quiet_armed <= 1'b0;
			end
		end
	end

	// ==========================================================================
	// Character completion.
	// ==========================================================================
	assign done_msb   = nine_bit ? done_data[8] : done_data[7];
	assign parity_bad = (nine_bit ? ^done_data : ^done_data[7:0])
		!= control_one[URX_C1_PARITY_TYPE];
	// In standby, characters are dropped unless an address mark wakes the unit.
	assign accept = done && (!receiver_standby || (wake_addr && done_msb));

	// ==========================================================================
	// Wishbone slave: ack one cycle after the request, read data registered.
	// ==========================================================================
	assign bus_req        = wb_cyc_in & wb_stb_in;
	assign wr_en          = bus_req & wb_we_in & wb_ack_out;
	assign rd_data_buffer = bus_req & ~wb_we_in & wb_ack_out
		& (wb_adr_in == URX_DATA_BUFFER_OFS);
	assign wr_status      = wr_en & wb_sel_in[0] & (wb_adr_in == URX_STATUS_ONE_OFS);

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[URX_ST_FULL]    = receive_full_flag;
		status_word[URX_ST_QUIET]   = quiet_flag;
		status_word[URX_ST_OVERRUN] = overrun_flag;
		status_word[URX_ST_NOISE]   = noise_flag;
		status_word[URX_ST_FRAMING] = framing_fault_flag;
		status_word[URX_ST_PARITY]  = parity_fault_flag;
		status_word[URX_ST_BUSY]    = (state != URX_HUNT);
		unique case (wb_adr_in)
			URX_DATA_BUFFER_OFS:   next_dat = {23'h000000, data_buffer};
			URX_STATUS_ONE_OFS:    next_dat = status_word;
			URX_CONTROL_ONE_OFS:   next_dat = {24'h000000, control_one};
			URX_CONTROL_TWO_OFS:   next_dat = {24'h000000, control_two};
			URX_CONTROL_THREE_OFS: next_dat = {24'h000000, control_three};
			URX_DIVISOR_OFS:       next_dat = {16'h0000, divisor};
			default:               next_dat = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wb_ack_out <= 1'b0;
			wb_dat_out <= 32'h0000_0000;
		end else begin
			wb_ack_out <= bus_req & ~wb_ack_out;
			if (bus_req && !wb_ack_out && !wb_we_in) begin
				wb_dat_out <= next_dat;
			end
		end
	end

	// ==========================================================================
	// Control registers.
	// ==========================================================================
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			control_one   <= URX_CONTROL_RST;
			control_two   <= URX_CONTROL_RST;
			control_three <= URX_CONTROL_RST;
			divisor       <= URX_DIVISOR_RST;
		end else begin
			if (wr_en && wb_sel_in[0] && wb_adr_in == URX_CONTROL_ONE_OFS) begin
				control_one <= {3'b000, wb_dat_in[4:0]};
			end
			if (wr_en && wb_sel_in[0] && wb_adr_in == URX_CONTROL_THREE_OFS) begin
				control_three <= {4'h0, wb_dat_in[3:0]};
			end
			if (wr_en && wb_adr_in == URX_DIVISOR_OFS) begin
				if (wb_sel_in[0]) begin
					divisor[7:0] <= wb_dat_in[7:0];
				end
				if (wb_sel_in[1]) begin
					divisor[15:8] <= wb_dat_in[15:8];
				end
			end
			if (wr_en && wb_sel_in[0] && wb_adr_in == URX_CONTROL_TWO_OFS) begin
				control_two <= {5'h00, wb_dat_in[2:0]};
			end else if (receiver_standby && accept) begin
				control_two[URX_C2_STANDBY] <= 1'b0;
			end else if (receiver_standby && !wake_addr && quiet_line) begin
				control_two[URX_C2_STANDBY] <= 1'b0;
			end
		end
	end

	// ==========================================================================
	// Status flags: hardware set wins over a software clear in the same cycle.
	// ==========================================================================
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			data_buffer        <= 9'h000;
			receive_full_flag  <= 1'b0;
			quiet_flag         <= 1'b0;
			overrun_flag       <= 1'b0;
			noise_flag         <= 1'b0;
			framing_fault_flag <= 1'b0;
			parity_fault_flag  <= 1'b0;
		end else begin
			if (wr_status) begin
				quiet_flag         <= quiet_flag & ~wb_dat_in[URX_ST_QUIET];
				overrun_flag       <= overrun_flag & ~wb_dat_in[URX_ST_OVERRUN];
				noise_flag         <= noise_flag & ~wb_dat_in[URX_ST_NOISE];
				framing_fault_flag <= framing_fault_flag & ~wb_dat_in[URX_ST_FRAMING];
				parity_fault_flag  <= parity_fault_flag & ~wb_dat_in[URX_ST_PARITY];
			end
			if (rd_data_buffer || (wr_status && wb_dat_in[URX_ST_FULL])) begin
				receive_full_flag <= 1'b0;
			end
			if (accept) begin
				if (receive_full_flag && !rd_data_buffer) begin
					overrun_flag <= 1'b1;
				end else begin
					data_buffer        <= done_data;
					receive_full_flag  <= 1'b1;
					framing_fault_flag <= done_framing;
					noise_flag         <= done_noise;
					parity_fault_flag  <= control_one[URX_C1_PARITY_EN]
						& parity_bad;
				end
			end
			if (quiet_event && !(receiver_standby && !wake_addr)) begin
				quiet_flag <= 1'b1;
			end
		end
	end

	// ==========================================================================
	// Interrupt requests.
	// ==========================================================================
	assign rx_irq_out = ~receiver_standby & (
		(receive_full_flag & control_two[URX_C2_FULL_IRQ])
		| (quiet_flag & control_two[URX_C2_QUIET_IRQ]));

	assign err_irq_out = ~receiver_standby & (
		(overrun_flag & control_three[URX_C3_OVERRUN_IRQ])
		| (noise_flag & control_three[URX_C3_NOISE_IRQ])
		| (framing_fault_flag & control_three[URX_C3_FRAMING_IRQ])
		| (parity_fault_flag & control_three[URX_C3_PARITY_IRQ]));

endmodule : urx_receiver

// ==== hdl/urx_pkg.sv ====
package urx_pkg;

	// ==========================================================================
	// Register offsets (byte addresses, one word each).
	// ==========================================================================
	localparam logic [7:0] URX_DATA_BUFFER_OFS   = 8'h00;
	localparam logic [7:0] URX_STATUS_ONE_OFS    = 8'h04;
	localparam logic [7:0] URX_CONTROL_ONE_OFS   = 8'h08;
	localparam logic [7:0] URX_CONTROL_TWO_OFS   = 8'h0C;
	localparam logic [7:0] URX_CONTROL_THREE_OFS = 8'h10;
	localparam logic [7:0] URX_DIVISOR_OFS       = 8'h14;

	// ==========================================================================
	// Field positions.
	// ==========================================================================
	localparam int URX_ST_FULL    = 0;
	localparam int URX_ST_QUIET   = 1;
	localparam int URX_ST_OVERRUN = 2;
	localparam int URX_ST_NOISE   = 3;
	localparam int URX_ST_FRAMING = 4;
	localparam int URX_ST_PARITY  = 5;
	localparam int URX_ST_BUSY    = 6;

	localparam int URX_C1_NINE_BIT    = 0;
	localparam int URX_C1_WAKE_ADDR   = 1;
	localparam int URX_C1_QUIET_START = 2;
	localparam int URX_C1_PARITY_EN   = 3;
	localparam int URX_C1_PARITY_TYPE = 4;

	localparam int URX_C2_FULL_IRQ  = 0;
	localparam int URX_C2_QUIET_IRQ = 1;
	localparam int URX_C2_STANDBY   = 2;

	localparam int URX_C3_OVERRUN_IRQ = 0;
	localparam int URX_C3_NOISE_IRQ   = 1;
	localparam int URX_C3_FRAMING_IRQ = 2;
	localparam int URX_C3_PARITY_IRQ  = 3;

	// ==========================================================================
	// Reset values and timing counts.
	// ==========================================================================
	localparam logic [7:0]  URX_CONTROL_RST = 8'h00;
	localparam logic [15:0] URX_DIVISOR_RST = 16'h0082;
	localparam logic [4:0]  URX_TICKS_PER_BIT = 5'h10;
	localparam logic [7:0]  URX_QUIET_TICKS_8 = 8'hA0;
	localparam logic [7:0]  URX_QUIET_TICKS_9 = 8'hB0;

	typedef enum logic [1:0] {
		URX_HUNT,
		URX_START,
		URX_DATA,
		URX_STOP
	} urx_state_t;

endpackage : urx_pkg

// ==== test/urx_receiver_checker.sv ====
`timescale 1ns/100ps
// ==========================================================================
// Port checks for the receiver.
// ==========================================================================
module urx_receiver_checker
	import urx_pkg::*;
(
	input  wire logic        mclk_in,
	input  wire logic        rst_n_in,
	input  wire logic        rxd_in,
	input  wire logic        wb_cyc_in,
	input  wire logic        wb_stb_in,
	input  wire logic        wb_we_in,
	input  wire logic [7:0]  wb_adr_in,
	input  wire logic [3:0]  wb_sel_in,
	input  wire logic [31:0] wb_dat_in,
	input  wire logic [31:0] wb_dat_out,
	input  wire logic        wb_ack_out,
	input  wire logic        rx_irq_out,
	input  wire logic        err_irq_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);

	logic [4:0] c1_shadow;
	logic [1:0] c2_shadow;
	logic [3:0] c3_shadow;
	logic       wr_take;
	logic       rd_take;

	assign wr_take = wb_ack_out && wb_cyc_in && wb_stb_in && wb_we_in && wb_sel_in[0];
	assign rd_take = wb_ack_out && wb_cyc_in && wb_stb_in && !wb_we_in;

	// Shadows of the enable and format bits, updated at the accepting edge.
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			c1_shadow <= 5'h00;
			c2_shadow <= 2'h0;
			c3_shadow <= 4'h0;
		end else if (wr_take) begin
			if (wb_adr_in == URX_CONTROL_ONE_OFS) c1_shadow <= wb_dat_in[4:0];
			if (wb_adr_in == URX_CONTROL_TWO_OFS) c2_shadow <= wb_dat_in[1:0];
			if (wb_adr_in == URX_CONTROL_THREE_OFS) c3_shadow <= wb_dat_in[3:0];
		end
	end

	ack_follows_req_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
		else $error("ack missing one cycle after request");
	ack_single_a: assert property (wb_ack_out |=> !wb_ack_out)
		else $error("ack longer than one cycle");
	ack_cause_a: assert property ($rose(wb_ack_out) |-> $past(wb_cyc_in && wb_stb_in))
		else $error("ack without request");
	unmapped_zero_a: assert property (rd_take && wb_adr_in > URX_DIVISOR_OFS |-> wb_dat_out == 32'h0)
		else $error("unmapped read not zero");
	format_readback_a: assert property (
		rd_take && wb_adr_in == URX_CONTROL_ONE_OFS |-> wb_dat_out == {27'h0, c1_shadow})
		else $error("control one read back wrong");
	buffer_width_a: assert property (
		rd_take && wb_adr_in == URX_DATA_BUFFER_OFS |-> wb_dat_out[31:9] == 23'h0
		&& (c1_shadow[0] || !wb_dat_out[8])) else $error("data buffer width wrong");
	rx_enable_gate_a: assert property (c2_shadow == 2'h0 |-> !rx_irq_out)
		else $error("receive request with enables clear");
	err_enable_gate_a: assert property (c3_shadow == 4'h0 |-> !err_irq_out)
		else $error("error request with enables clear");
	rx_fall_bus_a: assert property ($fell(rx_irq_out) |-> $past(wb_ack_out))
		else $error("receive request fell without bus access");
endmodule : urx_receiver_checker

// ==== test/urx_line_model.sv ====
`timescale 1ns/100ps
// ==========================================================================
// Remote transmitter: sixteen clocks a bit, line high at rest.
// ==========================================================================
module urx_line_model (
	input  wire logic mclk_in,
	output logic      rxd_out
);
	// Clocks per bit; the bench stretches it to exercise resynchronisation.
	int bit_len = 16;

	initial rxd_out = 1'h1;

	// Bit g gets a one-clock inverted pulse near mid-bit, to make noise.
	task automatic send(input logic [8:0] d, input int nb, input logic stp, input int g);
		logic v;
		for (int i = 0; i <= nb + 1; i++) begin
			v = (i == 0) ? 1'h0 : (i <= nb) ? d[i - 1] : stp;
			for (int c = 0; c < bit_len; c++) begin
				rxd_out <= (i == g && c == 8) ? !v : v;
				@(posedge mclk_in);
			end
		end
		rxd_out <= 1'h1;
	endtask : send
endmodule : urx_line_model

// ==== test/urx_receiver_tb.sv ====
`timescale 1ns/100ps
// ==========================================================================
// Self-checking bench with a behavioural model of the receiver.
// ==========================================================================
module urx_receiver_tb
	import urx_pkg::*;
;
	logic        mclk_in = 1'h0;
	logic        rst_n_in = 1'h0;
	logic        rxd;
	logic        wb_cyc_in = 1'h0;
	logic        wb_stb_in = 1'h0;
	logic        wb_we_in = 1'h0;
	logic [7:0]  wb_adr_in = 8'h00;
	logic [3:0]  wb_sel_in = 4'hF;
	logic [31:0] wb_dat_in = 32'h0;
	logic [31:0] wb_dat_out;
	logic        wb_ack_out;
	logic        rx_irq_out;
	logic        err_irq_out;
	logic [31:0] q;
	logic [31:0] seed = 32'h8F62;
	logic [8:0]  m_buf = 9'h000;
	logic        m_full = 1'h0, m_ovr = 1'h0, m_nf = 1'h0, m_fe = 1'h0, m_pe = 1'h0;
	logic        m_sb = 1'h0;
	logic [4:0]  c1 = 5'h00;
	logic [2:0]  c2 = 3'h0;
	logic [3:0]  c3 = 4'h0;
	int          errors = 0;
	int          checks = 0;

	always #25 mclk_in = ~mclk_in;

	urx_line_model urx_line_model_inst (.mclk_in(mclk_in), .rxd_out(rxd));

	urx_receiver urx_receiver_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .rxd_in(rxd),
		.wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
		.wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
		.wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .rx_irq_out(rx_irq_out),
		.err_irq_out(err_irq_out));

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs

	task automatic summarize();
		$display("errors=%0d checks=%0d", errors, checks);
		if (errors == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : summarize

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		wb_cyc_in <= 1'h1;
		wb_stb_in <= 1'h1;
		wb_we_in <= w;
		wb_adr_in <= a;
		wb_dat_in <= d;
		@(posedge mclk_in);
		while (wb_ack_out !== 1'h1 && n < 16) begin
			@(posedge mclk_in);
			n++;
		end
		q = wb_dat_out;
		chk({31'h0, wb_ack_out}, 32'h1, "bus ack");
		wb_cyc_in <= 1'h0;
		wb_stb_in <= 1'h0;
		@(posedge mclk_in);
	endtask : wb

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
		wb(1'h0, a, 32'h0);
		chk(q, e, m);
	endtask : rd

	task automatic cfg(input logic [4:0] n1, input logic [2:0] n2, input logic [3:0] n3);
		c1 = n1;
		c2 = n2;
		c3 = n3;
		m_sb = n2[2];
		wb(1'h1, URX_CONTROL_ONE_OFS, {27'h0, n1});
		wb(1'h1, URX_CONTROL_THREE_OFS, {28'h0, n3});
		wb(1'h1, URX_CONTROL_TWO_OFS, {29'h0, n2});
	endtask : cfg

	// Sends one character and updates the model as the receiver should.
	task automatic xfer(input logic [8:0] d, input logic stp, input int g);
		logic [8:0] dm;
		logic       msb;
		dm = c1[0] ? d : {1'h0, d[7:0]};
		msb = c1[0] ? d[8] : d[7];
		urx_line_model_inst.send(dm, c1[0] ? 9 : 8, stp, g);
		repeat (4) @(posedge mclk_in);
		if (m_sb && c1[1] && msb) m_sb = 1'h0;
		if (!m_sb && m_full) m_ovr = 1'h1;
		else if (!m_sb) begin
			m_buf = dm;
			m_full = 1'h1;
			m_fe = !stp;
			m_nf = (g >= 0);
			m_pe = c1[3] && ((^dm) != c1[4]);
		end
	endtask : xfer

	task automatic chkc();
		chk({31'h0, rx_irq_out}, {31'h0, m_full & c2[0] & !m_sb}, "rx request");
		chk({31'h0, err_irq_out}, {31'h0, ((m_ovr & c3[0]) | (m_nf & c3[1]) | (m_fe & c3[2])
			| (m_pe & c3[3])) & !m_sb}, "err request");
		wb(1'h0, URX_STATUS_ONE_OFS, 32'h0);
		chk(q & 32'h3D, {26'h0, m_pe, m_fe, m_nf, m_ovr, 1'h0, m_full}, "status");
		rd(URX_DATA_BUFFER_OFS, {23'h0, m_buf}, "data");
		wb(1'h1, URX_STATUS_ONE_OFS, 32'h3F);
		{m_full, m_ovr, m_nf, m_fe, m_pe} = 5'h00;
	endtask : chkc

	initial begin
		repeat (60000) @(posedge mclk_in);
		errors++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		summarize();
	end

	initial begin
		repeat (12) @(posedge mclk_in);
		rst_n_in <= 1'h1;
		@(posedge mclk_in);
		for (int i = 0; i < 7; i++) begin
			rd(8'(i * 4), (i == 5) ? {16'h0, URX_DIVISOR_RST} : 32'h0, "reset value");
		end
		wb(1'h1, URX_DIVISOR_OFS, 32'h1);
		cfg(5'h00, 3'h1, 4'h0);
		repeat (5) begin
			seed = xs(seed);
			xfer(seed[8:0], 1'h1, -1);
			chkc();
		end
		urx_line_model_inst.bit_len = 17;
		xfer(9'h055, 1'h1, -1);
		chkc();
		urx_line_model_inst.bit_len = 16;
		cfg(5'h00, 3'h1, 4'h2);
		for (int g = 0; g < 10; g += 3) begin
			seed = xs(seed);
			xfer(seed[8:0], 1'h1, g);
			chkc();
		end
		cfg(5'h00, 3'h1, 4'h4);
		xfer(seed[17:9], 1'h0, -1);
		chkc();
		xfer(9'h000, 1'h0, -1);
		chkc();
		cfg(5'h00, 3'h1, 4'h1);
		xfer(seed[8:0], 1'h1, -1);
		xfer(seed[16:8], 1'h1, -1);
		chkc();
		for (int k = 0; k < 4; k++) begin
			seed = xs(seed);
			cfg({k[1], 1'h1, 1'h0, 1'h0, !k[0]}, 3'h1, 4'h8);
			xfer(seed[8:0], 1'h1, -1);
			chkc();
			xfer(seed[8:0] ^ 9'h001, 1'h1, -1);
			chkc();
		end
		cfg(5'h02, 3'h5, 4'h0);
		xfer(9'h012, 1'h1, -1);
		chkc();
		xfer(9'h092, 1'h1, -1);
		rd(URX_CONTROL_TWO_OFS, 32'h1, "standby left");
		chkc();
		for (int s = 0; s < 2; s++) begin
			cfg({2'h0, s[0], 2'h0}, 3'h2, 4'h0);
			seed = xs(seed);
			xfer(seed[8:0], 1'h1, -1);
			chkc();
			repeat (200) @(posedge mclk_in);
			rd(URX_STATUS_ONE_OFS, 32'h2, "idle flag");
			chk({31'h0, rx_irq_out}, 32'h1, "idle request");
			wb(1'h1, URX_STATUS_ONE_OFS, 32'h3F);
		end
		cfg(5'h00, 3'h4, 4'h0);
		repeat (4) @(posedge mclk_in);
		rd(URX_CONTROL_TWO_OFS, 32'h0, "idle wake");
		rd(URX_STATUS_ONE_OFS, 32'h0, "wake flags");
		summarize();
	end
endmodule : urx_receiver_tb

bind urx_receiver urx_receiver_checker urx_receiver_checker_inst (.mclk_in(mclk_in),
	.rst_n_in(rst_n_in), .rxd_in(rxd_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
	.wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
	.wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .rx_irq_out(rx_irq_out),
	.err_irq_out(err_irq_out));
